//--- desb_bank.v
`timescale 1ns/1ps
// Contract
// - error word bits 4,6,9,12 flag nvm, setting, model data, model mismatch faults.
// - configuration word bit 8 set when unit sits left of leftmost head unit.
// - status word bit 1 set when second ram save area save was cut short.
// - status word bit 3 set when configuration or read-list registration was cut short.
// - status word bit 8 shows write mode: 0 backup, 1 ram-only.
// - status word bit 9 is 1 when working settings differ from stored copy.
// - summary word bit 1 set whenever any configuration error flag is active.
`include "desb_map.vh"

module desb_bank (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // avalon-mm slave
  input wire [9:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  // health sources, levels from device logic
  input wire i_nvm_fault,
  input wire i_setting_fault,
  input wire i_model_data_fault,
  input wire i_model_mismatch_fault,
  input wire i_illegal_arrangement,
  input wire i_save_area_incomplete,
  input wire i_registration_incomplete,
  input wire i_ram_differs_nvm,
  // write mode to the rest of the device
  output wire o_ram_only_mode,
  // interrupt
  output wire o_irq
);

  // ****************************************
  // internal state
  // ****************************************

  // status words as software sees them
  reg [15:0] mem_err;
  reg [15:0] cfg_err;
  reg [15:0] save_wm;

  // next values of the status words
  reg [15:0] next_mem_err;
  reg [15:0] next_cfg_err;
  reg [15:0] next_save_wm;

  // write mode chosen by software
  reg mode_ram_only;
  reg next_mode_ram_only;

  // interrupt status and mask
  reg [15:0] irq_stat;
  reg [15:0] irq_mask;
  reg [15:0] next_irq_stat;
  reg [15:0] next_irq_mask;

  // bus handshake and read path
  reg ack;
  reg next_ack;
  reg [31:0] next_readdata;

  // decoded bus strobes
  wire [7:0] idx;
  wire req;
  wire take_rd;
  wire take_wr;
  wire done_wr;

  // derived words
  wire [15:0] summary;
  wire [15:0] events;
  wire mem_any;
  wire cfg_any;

  // ****************************************
  // bus decode
  // ****************************************

  // word index; byte lanes inside a word are ignored
  assign idx = i_avs_address[9:2];

  // any request on the bus
  assign req = i_avs_read | i_avs_write;

  // first cycle of an access, when the slave takes it
  assign take_rd = i_avs_read & ~ack;
  assign take_wr = i_avs_write & ~ack;

  // completing cycle of a write; the write lands where waitrequest is low
  assign done_wr = i_avs_write & ack;

  // ****************************************
  // status word next values
  // ****************************************

  // memory fault bits
  // unused positions stay zero by building from the reset word
  always @* begin
    next_mem_err = `DESB_STAT_RST;
    next_mem_err[`DESB_MEM_NVM_BIT] = i_nvm_fault;
    next_mem_err[`DESB_MEM_SET_BIT] = i_setting_fault;
    next_mem_err[`DESB_MEM_MDATA_BIT] = i_model_data_fault;
    next_mem_err[`DESB_MEM_MMIS_BIT] = i_model_mismatch_fault;
  end

  always @* begin
    next_cfg_err = `DESB_STAT_RST;
    next_cfg_err[`DESB_CFG_ARR_BIT] = i_illegal_arrangement;
  end

  // save faults, write mode and match flag
  always @* begin
    next_save_wm = `DESB_STAT_RST;
    next_save_wm[`DESB_SWM_SAVE_BIT] = i_save_area_incomplete;
    next_save_wm[`DESB_SWM_REG_BIT] = i_registration_incomplete;
    next_save_wm[`DESB_SWM_MODE_BIT] = mode_ram_only;
    next_save_wm[`DESB_SWM_MATCH_BIT] = i_ram_differs_nvm;
  end

  // ****************************************
  // status word registers
  // ****************************************

  // memory word follows its sources one cycle late
  always @(posedge i_clk) begin
    if (i_rst) begin
      mem_err <= `DESB_STAT_RST;
    end else begin
      mem_err <= next_mem_err;
    end
  end

  // configuration word, same one cycle lag
  always @(posedge i_clk) begin
    if (i_rst) begin
      cfg_err <= `DESB_STAT_RST;
    end else begin
      cfg_err <= next_cfg_err;
    end
  end

  // save and mode word, same one cycle lag
  always @(posedge i_clk) begin
    if (i_rst) begin
      save_wm <= `DESB_STAT_RST;
    end else begin
      save_wm <= next_save_wm;
    end
  end

  // ****************************************
  // summary and interrupt events
  // ****************************************

  // any flag in a word counts as an error of that word
  assign mem_any = |mem_err;
  assign cfg_any = |cfg_err;

  assign summary = {14'h0000, cfg_any, mem_any};

  // events share the summary layout plus the two save faults
  assign events = {12'h000, save_wm[`DESB_SWM_REG_BIT], save_wm[`DESB_SWM_SAVE_BIT], summary[1:0]};

  // read clear loses to a new event in the same cycle
  // clearing at the take edge keeps it in step with the read snapshot
  always @* begin
    if (take_rd && (idx == `DESB_IDX_IRQ_STAT)) begin
      next_irq_stat = events;
    end else begin
      next_irq_stat = irq_stat | events;
    end
  end

  // sticky interrupt status
  always @(posedge i_clk) begin
    if (i_rst) begin
      irq_stat <= `DESB_STAT_RST;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // ****************************************
  // software writable registers
  // ****************************************

  // only mask is written by this block
  // only four event bits exist, so upper mask bits stay zero
  always @* begin
    if (done_wr && (idx == `DESB_IDX_IRQ_MASK)) begin
      next_irq_mask = {12'h000, i_avs_writedata[3:0]};
    end else begin
      next_irq_mask = irq_mask;
    end
  end

  // interrupt mask register
  always @(posedge i_clk) begin
    if (i_rst) begin
      irq_mask <= `DESB_MASK_RST;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  // status words ignore writes
  // a write to any status index falls through and changes nothing
  always @* begin
    if (done_wr && (idx == `DESB_IDX_MODE_CTRL)) begin
      next_mode_ram_only = i_avs_writedata[0];
    end else begin
      next_mode_ram_only = mode_ram_only;
    end
  end

  // write mode register, backup mode after reset
  always @(posedge i_clk) begin
    if (i_rst) begin
      mode_ram_only <= `DESB_MODE_RST;
    end else begin
      mode_ram_only <= next_mode_ram_only;
    end
  end

  // ****************************************
  // bus slave
  // ****************************************

  // one wait state on every access so read data comes from a flop
  assign o_avs_waitrequest = req & ~ack;

  // ack is high for the single completing cycle of each access
  always @* begin
    next_ack = req & ~ack;
  end

  // handshake state
  always @(posedge i_clk) begin
    if (i_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end

  always @* begin
    if (idx == `DESB_IDX_SUMMARY) begin
      next_readdata = {16'h0000, summary};
    end else if (idx == `DESB_IDX_MEM_ERR) begin
      next_readdata = {16'h0000, mem_err};
    end else if (idx == `DESB_IDX_CFG_ERR) begin
      next_readdata = {16'h0000, cfg_err};
    end else if (idx == `DESB_IDX_SAVE_WM) begin
      next_readdata = {16'h0000, save_wm};
    end else if (idx == `DESB_IDX_IRQ_STAT) begin
      next_readdata = {16'h0000, irq_stat};
    end else if (idx == `DESB_IDX_IRQ_MASK) begin
      next_readdata = {16'h0000, irq_mask};
    end else if (idx == `DESB_IDX_MODE_CTRL) begin
      next_readdata = {31'h00000000, mode_ram_only};
    end else begin
      next_readdata = 32'h00000000;
    end
  end

  // read data latched at the take edge, held until the next read
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h00000000;
    end else if (take_rd) begin
      o_avs_readdata <= next_readdata;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  // level interrupt while any unmasked event is pending
  assign o_irq = |(irq_stat & irq_mask);

  // write mode for the rest of the device
  assign o_ram_only_mode = mode_ram_only;

  // take_wr is kept for symmetry with the read side
  // a write does its work on the completing edge instead

endmodule

//--- desb_map.vh
`ifndef DESB_MAP_VH
`define DESB_MAP_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define DESB_IDX_MEM_ERR 8'h01
`define DESB_IDX_CFG_ERR 8'h02
`define DESB_IDX_SAVE_WM 8'h13
`define DESB_IDX_SUMMARY 8'h00
`define DESB_IDX_IRQ_STAT 8'h20
`define DESB_IDX_IRQ_MASK 8'h21
`define DESB_IDX_MODE_CTRL 8'h22

// ****************************************
// field positions
// ****************************************
`define DESB_MEM_NVM_BIT 4
`define DESB_MEM_SET_BIT 6
`define DESB_MEM_MDATA_BIT 9
`define DESB_MEM_MMIS_BIT 12
`define DESB_CFG_ARR_BIT 8
`define DESB_SUM_MEM_BIT 0
`define DESB_SUM_CFG_BIT 1
`define DESB_SWM_SAVE_BIT 1
`define DESB_SWM_REG_BIT 3
`define DESB_SWM_MODE_BIT 8
`define DESB_SWM_MATCH_BIT 9

// ****************************************
// reset values and masks
// ****************************************
`define DESB_MASK_RST 16'h0000
`define DESB_STAT_RST 16'h0000
`define DESB_MODE_RST 1'b0

`endif

//--- desb_props.sv
`timescale 1ns/1ps
module desb_props(input wire i_clk,i_rst,i_avs_read,i_avs_write,o_avs_waitrequest,o_ram_only_mode,
  i_illegal_arrangement,i_nvm_fault,i_setting_fault,i_model_data_fault,i_model_mismatch_fault,
  i_save_area_incomplete,i_registration_incomplete,i_ram_differs_nvm,
  input wire [9:0] i_avs_address,input wire [31:0] i_avs_writedata,o_avs_readdata);
  wire d=i_avs_read&~o_avs_waitrequest;
  wire [7:0] x=i_avs_address[9:2];
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_cfg; d&&x==8'h02|->o_avs_readdata[8]==$past(i_illegal_arrangement,2); endproperty
  a_cfg: assert property(p_cfg) else $error("cfg");
  property p_sum; d&&x==8'h00|->o_avs_readdata[1]==$past(i_illegal_arrangement,2); endproperty
  a_sum: assert property(p_sum) else $error("sum");
  property p_mode; i_avs_write&&!o_avs_waitrequest&&x==8'h22|=>o_ram_only_mode==$past(i_avs_writedata[0]); endproperty
  a_mode: assert property(p_mode) else $error("mode");
  property p_hi; d|->o_avs_readdata[31:16]==16'h0; endproperty
  a_hi: assert property(p_hi) else $error("hi");
  sequence s_rd_mem; d&&x==8'h01; endsequence
  sequence s_rd_swm; d&&x==8'h13; endsequence
  sequence s_taken; (i_avs_read||i_avs_write)&&o_avs_waitrequest; endsequence
  property p_mem; s_rd_mem|->o_avs_readdata[15:0]=={3'b000,$past(i_model_mismatch_fault,2),2'b00,
    $past(i_model_data_fault,2),2'b00,$past(i_setting_fault,2),1'b0,$past(i_nvm_fault,2),4'h0}; endproperty
  a_mem: assert property(p_mem) else $error("mem");
  property p_swm; s_rd_swm|->o_avs_readdata[15:0]=={6'h00,$past(i_ram_differs_nvm,2),$past(o_ram_only_mode,2),
    4'h0,$past(i_registration_incomplete,2),1'b0,$past(i_save_area_incomplete,2),1'b0}; endproperty
  a_swm: assert property(p_swm) else $error("swm");
  property p_ans; s_taken|=>!o_avs_waitrequest; endproperty
  a_ans: assert property(p_ans) else $error("ans");
endmodule
bind desb_bank desb_props u_props(.*);

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg i_clk=1'b0,i_rst=1'b1,rd=1'b0,wr=1'b0;
  reg [7:0] f=8'h00;
  reg [9:0] a=10'h000;
  reg [31:0] wd=32'h0,r;
  wire [31:0] q;
  wire w,md,irq;
  integer n_fail=0,n_tests=0;
  always #10 i_clk=~i_clk;
  desb_bank i_dut(.*,.i_avs_address(a),.i_avs_read(rd),.i_avs_write(wr),
    .i_avs_writedata(wd),.o_avs_readdata(q),.o_avs_waitrequest(w),.i_nvm_fault(f[0]),.i_setting_fault(f[1]),
    .i_model_data_fault(f[2]),.i_model_mismatch_fault(f[3]),.i_illegal_arrangement(f[4]),
    .i_save_area_incomplete(f[5]),.i_registration_incomplete(f[6]),.i_ram_differs_nvm(f[7]),
    .o_ram_only_mode(md),.o_irq(irq));
  // request held until waitrequest low
  task bus(input x,input [7:0] i,input [31:0] d);
    @(posedge i_clk);
    rd<=!x; wr<=x; a<={i,2'b00}; wd<=d;
    do @(posedge i_clk); while(w!==1'b0);
    r=q; rd<=1'b0; wr<=1'b0;
  endtask
  task chk(input string nm,input [31:0] s,e);
    n_tests=n_tests+1;
    if(s!==e) begin
      n_fail=n_fail+1;
      $display("ERROR %s exp %h got %h",nm,e,s);
    end
  endtask
  task rc(input string nm,input [7:0] i,input [31:0] e);
    bus(1'b0,i,32'h0);
    chk(nm,r,e);
  endtask
  task t_err;
    f<=8'hFF;
    rc("mem_err",8'h01,32'h1250);
    rc("cfg_err",8'h02,32'h100);
    rc("save_wm",8'h13,32'h20A);
    rc("summary",8'h00,32'h3);
    chk("irq_off",irq,1'b0);
  endtask
  task t_irq;
    bus(1'b1,8'h21,32'h1);
    @(posedge i_clk);
    chk("irq_on",irq,1'b1);
    f<=8'h00;
    rc("irq_stat",8'h20,32'hF);
    @(posedge i_clk);
    chk("irq_clr",irq,1'b0);
  endtask
  task t_wr;
    bus(1'b1,8'h22,32'h1);
    @(posedge i_clk);
    chk("mode_pin",md,1'b1);
    rc("mode_bit",8'h13,32'h100);
    bus(1'b1,8'h01,32'hFFFF);
    rc("ro_word",8'h01,32'h0);
    rc("unmapped",8'h30,32'h0);
  endtask
  task wrap_up;
    $display("tests %0d fails %0d",n_tests,n_fail);
    if(n_fail==0&&n_tests>0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat(5) @(posedge i_clk);
    i_rst<=1'b0; t_err; t_irq; t_wr; wrap_up;
  end
  initial begin
    repeat(2000) @(posedge i_clk); n_fail=n_fail+1; wrap_up;
  end
endmodule
